// ---- hw/power_mode_ctrl.sv ----
// Power mode controller top
// How it works
// - A sleep instruction enters wait or stop class according to the sleep configuration.
// - Normal run keeps every module running with the core active.
// - Very-low-power run slows all clocks and turns off low voltage detect.
// - Wait sleeps the core and keeps peripherals at full speed.
// - Very-low-power wait sleeps the core, slows peripherals and disables low voltage detect.
// - The nested interrupt controller wakes the core from both wait modes.
// - The async wake controller wakes the core from both stop modes.
// - Stop gates most clocks, retains registers and SRAM and keeps low voltage detect on.
// - Stop keeps converter, comparator, timer, clock and pin interrupts, with nested interrupts off.
// - Very-low-power stop retains SRAM, keeps its listed peripherals and disables detect and nested interrupts.
// - High-speed or very-low-power modes block EEPROM writes and flash commands.
// - A stop wake first asks clock control to restart clocks before the interrupt is serviced.
`timescale 1ns/1ns
`default_nettype none
`include "pmc_params.svh"
module power_mode_ctrl
    import power_mode_pkg::*;
(
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic [1:0] run_cfg,
    input wire logic sleep_cfg,
    input wire logic sleep_req,
    input wire logic nested_irq_wake,
    input wire logic async_wake_raw,
    input wire logic clk_restart_ack,
    output logic clk_restart_req,
    output logic irq_release,
    output var pm_mode_t cur_mode,
    output var pm_ctrl_t ctrl
);
    // =========================================================
    // Async wake input synchroniser, three stages
    logic [2:0] wake_sync_reg;
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            wake_sync_reg <= 3'h0;
        end else begin
            wake_sync_reg <= {wake_sync_reg[1:0], async_wake_raw};
        end
    end
    logic wake_level_reg;
    wire logic wake_agree = (wake_sync_reg[1] == wake_sync_reg[2]);
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            wake_level_reg <= 1'b0;
        end else if (wake_agree) begin
            wake_level_reg <= wake_sync_reg[2];
        end
    end

    // =========================================================
    // State, saved run setting, mode
    pm_state_t state_reg, state_next;
    logic [1:0] saved_run_reg, saved_run_next;
    logic vlp_sleep_reg, vlp_sleep_next;
    logic [7:0] timeout_reg, timeout_next;

    wire logic run_state = (state_reg == ST_RUN) || (state_reg == ST_VLP_RUN) || (state_reg == ST_HS_RUN);
    wire logic go_stop = (sleep_cfg == `SLEEP_CFG_STOP);
    wire logic timeout_hit = (timeout_reg == `CLK_RESTART_TIMEOUT);

    function automatic pm_state_t run_state_of(input logic [1:0] cfg);
        case (cfg)
            `RUN_CFG_VLP: run_state_of = ST_VLP_RUN;
            `RUN_CFG_HS: run_state_of = ST_HS_RUN;
            default: run_state_of = ST_RUN;
        endcase
    endfunction

    always_comb begin
        state_next = state_reg;
        saved_run_next = saved_run_reg;
        vlp_sleep_next = vlp_sleep_reg;
        timeout_next = 8'h00;
        case (state_reg)
            ST_RUN, ST_VLP_RUN, ST_HS_RUN: begin
                if (sleep_req) begin
                    saved_run_next = run_cfg;
                    vlp_sleep_next = (run_cfg == `RUN_CFG_VLP);
                    state_next = go_stop ? ST_STOP : ST_WAIT;
                end else begin
                    state_next = run_state_of(run_cfg);
                end
            end
            ST_WAIT: begin
                if (nested_irq_wake) begin
                    state_next = run_state_of(saved_run_reg);
                end
            end
            ST_STOP: begin
                if (wake_level_reg) begin
                    state_next = ST_WAKE_CLK;
                end
            end
            ST_WAKE_CLK: begin
                timeout_next = timeout_reg + 8'h01;
                if (clk_restart_ack || timeout_hit) begin
                    state_next = run_state_of(saved_run_reg);
                end
            end
            default: begin
                state_next = ST_RUN;
            end
        endcase
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            state_reg <= ST_RUN;
            saved_run_reg <= `RUN_CFG_NORMAL;
            vlp_sleep_reg <= 1'b0;
            timeout_reg <= 8'h00;
        end else begin
            state_reg <= state_next;
            saved_run_reg <= saved_run_next;
            vlp_sleep_reg <= vlp_sleep_next;
            timeout_reg <= timeout_next;
        end
    end

    // =========================================================
    // Current mode decode
    always_comb begin
        case (state_reg)
            ST_VLP_RUN: cur_mode = MODE_VLP_RUN;
            ST_HS_RUN: cur_mode = MODE_HS_RUN;
            ST_WAIT: cur_mode = vlp_sleep_reg ? MODE_VLP_WAIT : MODE_WAIT;
            ST_STOP, ST_WAKE_CLK: cur_mode = vlp_sleep_reg ? MODE_VLP_STOP : MODE_STOP;
            default: cur_mode = MODE_RUN;
        endcase
    end

    // Clock restart request, interrupt release in every run state, reached from stop after clock restart ack or restart timeout
    assign clk_restart_req = (state_reg == ST_WAKE_CLK);
    assign irq_release = run_state;

    // =========================================================
    // Per-mode control vector
    mode_decode i_mode_decode (
        .sys_clk(sys_clk),
        .resetn(resetn),
        .mode(cur_mode),
        .ctrl(ctrl)
    );
endmodule // power_mode_ctrl
`default_nettype wire

// ---- hw/pmc_params.svh ----
// Constants for the power mode controller
`ifndef POWER_MODE_PARAMS_SVH
`define POWER_MODE_PARAMS_SVH
// Mode configuration codes
`define RUN_CFG_NORMAL 2'h0
`define RUN_CFG_VLP 2'h1
`define RUN_CFG_HS 2'h2
`define SLEEP_CFG_WAIT 1'h0
`define SLEEP_CFG_STOP 1'h1
// Clock restart handshake bound, cycles
`define CLK_RESTART_TIMEOUT 8'hFF
// Peripheral enable vector positions
`define PER_ADC 0
`define PER_CMP 1
`define PER_LOW_POWER_TIMER 2
`define PER_RTC 3
`define PER_PIN_IRQ 4
`define PER_OSC 5
`define PER_PERIODIC_TIMER 6
`define PER_SERIAL 7
`define PER_DMA 8
`define PER_OTHER 9
`define PER_COUNT 10
`endif

// ---- hw/power_mode_pkg.sv ----
// Types for the power mode controller
package power_mode_pkg;
    typedef enum logic [5:0] {
        ST_RUN = 6'h01,
        ST_WAIT = 6'h02,
        ST_STOP = 6'h04,
        ST_WAKE_CLK = 6'h08,
        ST_VLP_RUN = 6'h10,
        ST_HS_RUN = 6'h20
    } pm_state_t;

    typedef enum logic [2:0] {
        MODE_RUN = 3'h0,
        MODE_VLP_RUN = 3'h1,
        MODE_WAIT = 3'h2,
        MODE_VLP_WAIT = 3'h3,
        MODE_STOP = 3'h4,
        MODE_VLP_STOP = 3'h5,
        MODE_HS_RUN = 3'h6
    } pm_mode_t;

    // Outputs grouped toward the rest of the chip
    typedef struct packed {
        logic core_sleep;
        logic clk_reduced;
        logic clk_gated;
        logic low_voltage_detect_en;
        logic nested_irq_en;
        logic async_wake_en;
        logic mem_retain;
        logic flash_cmd_allow;
        logic eeprom_write_allow;
        logic [9:0] periph_en;
    } pm_ctrl_t;
endpackage

// ---- hw/mode_decode.sv ----
// Mode to control-vector decoder, registered
`timescale 1ns/1ns
`default_nettype none
`include "pmc_params.svh"
module mode_decode
    import power_mode_pkg::*;
(
    input wire logic sys_clk,
    input wire logic resetn,
    input wire pm_mode_t mode,
    output var pm_ctrl_t ctrl
);
    // =========================================================
    // Combinational decode
    pm_ctrl_t ctrl_next;
    wire logic is_vlp = (mode == MODE_VLP_RUN) || (mode == MODE_VLP_WAIT) || (mode == MODE_VLP_STOP);
    wire logic is_stop = (mode == MODE_STOP) || (mode == MODE_VLP_STOP);
    wire logic is_sleep = (mode == MODE_WAIT) || (mode == MODE_VLP_WAIT) || is_stop;

    always_comb begin
        ctrl_next = '0;
        ctrl_next.core_sleep = is_sleep;
        ctrl_next.clk_reduced = is_vlp;
        ctrl_next.clk_gated = is_stop;
        ctrl_next.low_voltage_detect_en = !is_vlp;
        ctrl_next.nested_irq_en = !is_stop;
        ctrl_next.async_wake_en = is_stop;
        ctrl_next.mem_retain = 1'b1;
        ctrl_next.flash_cmd_allow = !is_vlp && (mode != MODE_HS_RUN);
        ctrl_next.eeprom_write_allow = !is_vlp && (mode != MODE_HS_RUN);
        case (mode)
            MODE_STOP: begin
                ctrl_next.periph_en[`PER_ADC] = 1'b1;
                ctrl_next.periph_en[`PER_CMP] = 1'b1;
                ctrl_next.periph_en[`PER_LOW_POWER_TIMER] = 1'b1;
                ctrl_next.periph_en[`PER_RTC] = 1'b1;
                ctrl_next.periph_en[`PER_PIN_IRQ] = 1'b1;
            end
            MODE_VLP_STOP: begin
                ctrl_next.periph_en = {`PER_COUNT{1'b1}};
                ctrl_next.periph_en[`PER_OTHER] = 1'b0;
            end
            default: begin
                ctrl_next.periph_en = {`PER_COUNT{1'b1}};
            end
        endcase
    end

    // =========================================================
    // Output register
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            ctrl <= '0;
        end else begin
            ctrl <= ctrl_next;
        end
    end
endmodule // mode_decode
`default_nettype wire

// ---- testbench/power_mode_ctrl_asserts.sv ----
// Concurrent checks on the power mode controller ports
`timescale 1ns/1ns
`default_nettype none
module power_mode_ctrl_asserts
    import power_mode_pkg::*;
(
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic [1:0] run_cfg,
    input wire logic sleep_cfg,
    input wire logic sleep_req,
    input wire logic nested_irq_wake,
    input wire logic async_wake_raw,
    input wire logic clk_restart_ack,
    input wire logic clk_restart_req,
    input wire logic irq_release,
    input wire pm_mode_t cur_mode,
    input wire pm_ctrl_t ctrl
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!resetn);
    pm_mode_t prev;
    wire pm_ctrl_t c = ctrl;
    wire in_stop = cur_mode inside {MODE_STOP, MODE_VLP_STOP};
    // Mode that the registered vector follows
    always_ff @(posedge sys_clk) prev <= cur_mode;
    // ==========
    // Entry and per-mode vectors
    sleep_entry_a: assert property (cur_mode == MODE_RUN && run_cfg == 2'h0 && sleep_req
        |=> cur_mode == ($past(sleep_cfg) ? MODE_STOP : MODE_WAIT)) else $error("wrong mode after sleep");
    run_vector_a: assert property ($past(resetn) && prev == MODE_RUN
        |-> !c.core_sleep && !c.clk_reduced && c.periph_en == 10'h3FF && c.flash_cmd_allow) else $error("run vector");
    vlp_run_vector_a: assert property (prev == MODE_VLP_RUN
        |-> c.clk_reduced && !c.low_voltage_detect_en && !c.flash_cmd_allow && !c.eeprom_write_allow) else $error("vlp run");
    wait_vector_a: assert property (prev == MODE_WAIT
        |-> c.core_sleep && !c.clk_reduced && c.periph_en == 10'h3FF && c.nested_irq_en) else $error("wait vector");
    vlp_wait_vector_a: assert property (prev == MODE_VLP_WAIT
        |-> c.core_sleep && c.clk_reduced && !c.low_voltage_detect_en && !c.flash_cmd_allow) else $error("vlp wait");
    stop_vector_a: assert property (prev == MODE_STOP |-> c.clk_gated && c.mem_retain
        && c.low_voltage_detect_en && !c.nested_irq_en && c.async_wake_en && c.periph_en[4:0] == 5'h1F) else $error("stop");
    vlp_stop_vector_a: assert property (prev == MODE_VLP_STOP |-> c.mem_retain && c.async_wake_en
        && !c.low_voltage_detect_en && !c.nested_irq_en && c.periph_en[8:0] == 9'h1FF) else $error("vlp stop");
    hs_run_vector_a: assert property (prev == MODE_HS_RUN
        |-> !c.core_sleep && !c.clk_reduced && !c.flash_cmd_allow && !c.eeprom_write_allow) else $error("hs run");
    // ==========
    // Wake path
    restart_gate_a: assert property (clk_restart_req |-> !irq_release) else $error("irq before clocks");
    stop_hold_a: assert property ((!async_wake_raw)[*6] ##0 (in_stop && !clk_restart_req)
        |=> cur_mode == $past(cur_mode)) else $error("stop left without wake");
    cover property (clk_restart_req && clk_restart_ack);
    cover property (cur_mode == MODE_VLP_STOP);
    cover property (cur_mode == MODE_VLP_WAIT && nested_irq_wake);
endmodule // power_mode_ctrl_asserts
bind power_mode_ctrl power_mode_ctrl_asserts i_power_mode_ctrl_asserts (.sys_clk(sys_clk), .resetn(resetn),
    .run_cfg(run_cfg), .sleep_cfg(sleep_cfg), .sleep_req(sleep_req), .nested_irq_wake(nested_irq_wake),
    .async_wake_raw(async_wake_raw), .clk_restart_ack(clk_restart_ack), .clk_restart_req(clk_restart_req),
    .irq_release(irq_release), .cur_mode(cur_mode), .ctrl(ctrl));
`default_nettype wire

// ---- testbench/clk_ctrl_model.sv ----
// Clock control partner answering restart requests
`timescale 1ns/1ns
`default_nettype none
module clk_ctrl_model (
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic clk_restart_req,
    input wire logic [3:0] delay,
    output logic clk_restart_ack
);
    logic [3:0] cnt_reg;
    // Ack for one cycle once the set delay has run
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            cnt_reg <= 4'h0;
            clk_restart_ack <= 1'b0;
        end else begin
            clk_restart_ack <= clk_restart_req && cnt_reg == delay && !clk_restart_ack;
            cnt_reg <= (clk_restart_req && cnt_reg != delay) ? cnt_reg + 4'h1 : 4'h0;
        end
    end
endmodule // clk_ctrl_model
`default_nettype wire

// ---- testbench/power_mode_ctrl_bench.sv ----
// Self-checking bench for the power mode controller
`timescale 1ns/1ns
`default_nettype none
module power_mode_ctrl_bench
    import power_mode_pkg::*;
;
    logic sys_clk = 1'b0, resetn = 1'b0, sleep_cfg = 1'b0, sleep_req = 1'b0;
    logic nested_irq_wake = 1'b0, async_wake_raw = 1'b0, clk_restart_ack, clk_restart_req, irq_release;
    logic [1:0] run_cfg = 2'h0;
    logic [3:0] delay = 4'h1;
    pm_mode_t cur_mode;
    pm_ctrl_t ctrl;
    int fail_count = 0, n_checks = 0;
    // Clock, controller and clock control partner
    initial forever #10 sys_clk = ~sys_clk;
    power_mode_ctrl i_power_mode_ctrl (.sys_clk(sys_clk), .resetn(resetn), .run_cfg(run_cfg), .sleep_cfg(sleep_cfg),
        .sleep_req(sleep_req), .nested_irq_wake(nested_irq_wake), .async_wake_raw(async_wake_raw),
        .clk_restart_ack(clk_restart_ack), .clk_restart_req(clk_restart_req), .irq_release(irq_release),
        .cur_mode(cur_mode), .ctrl(ctrl));
    clk_ctrl_model i_clk_ctrl_model (.sys_clk(sys_clk), .resetn(resetn), .clk_restart_req(clk_restart_req),
        .delay(delay), .clk_restart_ack(clk_restart_ack));
    // ==========
    // Shared helpers
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
    endtask
    task automatic chk(input string what, input logic [18:0] seen, input logic [18:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic results;
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic enter(input logic [1:0] rc, input logic sc, input pm_mode_t m);
        @(posedge sys_clk);
        run_cfg <= rc;
        sleep_cfg <= sc;
        tick(8);
        sleep_req <= 1'b1;
        tick(1);
        sleep_req <= 1'b0;
        tick(2);
        #1 chk("sleep mode", cur_mode, m);
        chk("core sleep", ctrl.core_sleep, 1'b1);
    endtask
    // Wrong source and repeated sleep first, then the listed source
    task automatic wake(input logic nw, input pm_mode_t s, input pm_mode_t m);
        int i;
        logic seen_req;
        logic [1:0] rc;
        seen_req = 1'b0;
        rc = run_cfg;
        @(posedge sys_clk);
        sleep_req <= 1'b1;
        run_cfg <= 2'h3; // Run setting moved while asleep
        nested_irq_wake <= !nw;
        async_wake_raw <= nw;
        tick(8);
        #1 chk("held", cur_mode, s);
        @(posedge sys_clk);
        sleep_req <= 1'b0;
        nested_irq_wake <= nw;
        async_wake_raw <= !nw;
        for (i = 0; i < 40 && irq_release !== 1'b1; i++) begin
            @(posedge sys_clk);
            #1 seen_req |= clk_restart_req;
        end
        if (i >= 40) begin
            fail_count++;
            results();
        end
        chk("restart", seen_req, !nw);
        chk("woke mode", cur_mode, m);
        @(posedge sys_clk);
        nested_irq_wake <= 1'b0;
        async_wake_raw <= 1'b0;
        run_cfg <= rc;
    endtask
    // ==========
    // Scenarios
    task automatic reset_check;
        tick(3);
        #1 chk("rst mode", cur_mode, MODE_RUN);
        chk("rst ctrl", ctrl, 19'h0);
        tick(3);
        resetn <= 1'b1;
        tick(2);
        #1 chk("run en", ctrl.periph_en, 10'h3FF);
        chk("run flash", ctrl.flash_cmd_allow, 1'b1);
    endtask
    task automatic wait_cycle;
        enter(2'h0, 1'b0, MODE_WAIT);
        chk("wait clk", ctrl.clk_reduced, 1'b0);
        wake(1'b1, MODE_WAIT, MODE_RUN);
    endtask
    task automatic stop_cycle;
        enter(2'h0, 1'b1, MODE_STOP);
        chk("retain", ctrl.mem_retain, 1'b1);
        wake(1'b0, MODE_STOP, MODE_RUN);
    endtask
    task automatic vlp_wait_cycle;
        enter(2'h1, 1'b0, MODE_VLP_WAIT);
        chk("very_low_power_wait detect", ctrl.low_voltage_detect_en, 1'b0);
        wake(1'b1, MODE_VLP_WAIT, MODE_VLP_RUN);
    endtask
    task automatic vlp_stop_cycle;
        delay <= 4'hF;
        enter(2'h1, 1'b1, MODE_VLP_STOP);
        chk("very_low_power_stop retain", ctrl.mem_retain, 1'b1);
        wake(1'b0, MODE_VLP_STOP, MODE_VLP_RUN);
        tick(2);
        #1 chk("very_low_power_run clk", ctrl.clk_reduced, 1'b1);
        chk("very_low_power_run flash", ctrl.flash_cmd_allow, 1'b0);
    endtask
    task automatic fast_run;
        @(posedge sys_clk);
        run_cfg <= 2'h2;
        tick(3);
        #1 chk("hs mode", cur_mode, MODE_HS_RUN);
        chk("hs flash", ctrl.flash_cmd_allow, 1'b0);
        chk("hs eeprom", ctrl.eeprom_write_allow, 1'b0);
        enter(2'h2, 1'b0, MODE_WAIT);
        wake(1'b1, MODE_WAIT, MODE_HS_RUN);
    endtask
    initial begin
        reset_check();
        wait_cycle();
        stop_cycle();
        vlp_wait_cycle();
        vlp_stop_cycle();
        fast_run();
        results();
    end
endmodule // power_mode_ctrl_bench
`default_nettype wire
